// ### dv/irq_gate_regs_bench.sv
// self-checking bench for the enable and level register block
`timescale 1ns/1ps
module irq_gate_regs_bench;
   import irq_gate_pkg::*;
   logic clk, rst, wr_s, rd_s, step, pend;   // clock, reset, strobes
   addr_type addr;                           // register index
   word_type wdata, rdata, g2, g3, g4, r2, r3, r4, f2, f3, f4;
   level_type l3, l2, l1, l0;                // level outputs
   logic [3:0] f0, r0, ez;                   // level bank flags, requests
   word_type m[0:4];                         // expected register contents
   word_type mk[0:4] = '{16'hDFFF, 16'h21FF, 16'h00F6, 16'h7777, 16'h0000};
   word_type exp_q[$];                       // expected read data
   int err_total = 0, n_checks = 0;
   irq_gate_regs irq_gate_regs_i (.clk_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr_s), .rd_i(rd_s), .flag_two_i(f2), .flag_three_i(f3), .flag_four_i(f4),
      .flag_zero_i(f0), .rdata_o(rdata), .gate_two_o(g2), .gate_three_o(g3), .gate_four_o(g4),
      .timer_one_level_o(l3), .out_cmp_one_level_o(l2), .in_capture_one_level_o(l1),
      .ext_line_zero_level_o(l0), .req_two_o(r2), .req_three_o(r3), .req_four_o(r4), .req_zero_o(r0));
   src_model src_model_i (.clk_i(clk), .step_i(step), .two_o(f2), .three_o(f3), .four_o(f4), .zero_o(f0));
   task check(input string n, input word_type s, input word_type e);
      n_checks++;
      if (s !== e) begin
         err_total++;
         $display("[ERR] %s exp %h got %h", n, e, s);
      end
   endtask
   task finish_test;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // one-cycle write; the model keeps only the implemented bits
   task wr(input addr_type a, input word_type d);
      @(posedge clk);
      addr <= a; wdata <= d; wr_s <= 1'b1; rd_s <= 1'b0;
      m[a] = d & mk[a];
   endtask
   // one-cycle read; the monitor compares the answer one cycle later
   task rd(input addr_type a);
      @(posedge clk);
      addr <= a; rd_s <= 1'b1; wr_s <= 1'b0;
      exp_q.push_back(m[a]);
   endtask
   // new flags, let copies settle, then compare every side output
   task chk_out;
      @(posedge clk);
      wr_s <= 1'b0; rd_s <= 1'b0; step <= 1'b1;
      @(posedge clk);
      step <= 1'b0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      for (int i = 0; i < 4; i++) ez[i] = f0[i] & (m[3][4*i+:3] != 3'h0);
      check("gate two", g2, m[0]);
      check("gate three", g3, m[1]);
      check("gate four", g4, m[2]);
      check("levels", {1'b0, l3, 1'b0, l2, 1'b0, l1, 1'b0, l0}, m[3]);
      check("req two", r2, f2 & m[0]);
      check("req three", r3, f3 & m[1]);
      check("req four", r4, f4 & m[2]);
      check("req zero", {12'h000, r0}, {12'h000, ez});
   endtask
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // read answers are valid only in the cycle after the strobe, zero otherwise
   always @(posedge clk) begin
      if (pend) check("rdata", rdata, exp_q.pop_front());
      else if (!rst) check("rdata idle", rdata, 16'h0000);
      pend <= rd_s & !rst;
   end
   initial begin
      #(25 * 5000);
      err_total++;
      finish_test;
   end
   initial begin
      {wr_s, rd_s, step, pend, addr, wdata} = '0;
      rst = 1'b1;
      m = '{16'h0000, 16'h0000, 16'h0000, 16'h4444, 16'h0000};
      void'($urandom(53584));
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      chk_out;
      for (int a = 0; a < 5; a++) rd(4'(a));
      for (int a = 0; a < 5; a++) wr(4'(a), 16'hFFFF);
      for (int a = 0; a < 5; a++) rd(4'(a));
      chk_out;
      // every level code, all four fields at once
      for (int c = 0; c < 8; c++) begin
         wr(4'h3, {4{1'b0, 3'(c)}});
         rd(4'h3);
         chk_out;
      end
      repeat (40) begin
         addr_type a;
         a = 4'($urandom % 5);
         wr(a, 16'($urandom));
         rd(a);
         chk_out;
      end
      // reset again mid-run: every register and output falls back
      @(posedge clk);
      wr_s <= 1'b0; rd_s <= 1'b0; rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      m = '{16'h0000, 16'h0000, 16'h0000, 16'h4444, 16'h0000};
      chk_out;
      for (int a = 0; a < 5; a++) rd(4'(a));
      chk_out;
      finish_test;
   end
endmodule

// ### dv/src_model.sv
// peripheral source model: random level request flags
`timescale 1ns/1ps
module src_model (
   input  wire logic        clk_i,   // bench clock
   input  wire logic        step_i,  // load a new pattern
   output logic      [15:0] two_o,   // bank two flags
   output logic      [15:0] three_o, // bank three flags
   output logic      [15:0] four_o,  // bank four flags
   output logic      [3:0]  zero_o   // level bank flags
);
   initial {two_o, three_o, four_o, zero_o} = '0;
   // flags hold between steps so the gated copies can settle
   always @(posedge clk_i) begin
      if (step_i) begin
         two_o   <= 16'($urandom);
         three_o <= 16'($urandom);
         four_o  <= 16'($urandom);
         zero_o  <= 4'($urandom);
      end
   end
endmodule

// ### hw/irq_gate_params.svh
// register offsets, implemented-bit masks, reset values and field positions
`ifndef IRQ_GATE_PARAMS_SVH
`define IRQ_GATE_PARAMS_SVH
`define OFS_GATE_TWO     4'h0
`define OFS_GATE_THREE   4'h1
`define OFS_GATE_FOUR    4'h2
`define OFS_LEVEL_ZERO   4'h3
`define MASK_GATE_TWO    16'hDFFF
`define MASK_GATE_THREE  16'h21FF
`define MASK_GATE_FOUR   16'h00F6
`define MASK_LEVEL_ZERO  16'h7777
`define RST_GATE         16'h0000
`define RST_LEVEL_ZERO   16'h4444
`define RST_LEVEL        3'h4
`define LVL_TIMER_ONE    12
`define LVL_OUT_CMP_ONE  8
`define LVL_IN_CAP_ONE   4
`define LVL_EXT_ZERO     0
`endif

// ### hw/irq_gate_pkg.sv
// types shared by the enable and priority register block
package irq_gate_pkg;
   typedef logic [15:0] word_type;   // one register word
   typedef logic [3:0]  addr_type;   // register index
   typedef logic [2:0]  level_type;  // priority level, 0 disables
endpackage

// ### hw/irq_gate_regs.sv
// interrupt enable banks two to four and priority bank zero
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`include "irq_gate_params.svh"
module irq_gate_regs (
   input  wire logic                  clk_i,        // 40 MHz clock
   input  wire logic                  rst_i,        // synchronous reset, high
   input  wire irq_gate_pkg::addr_type addr_i,      // register index
   input  wire irq_gate_pkg::word_type wdata_i,     // write data
   input  wire logic                  wr_i,         // write strobe
   input  wire logic                  rd_i,         // read strobe
   input  wire irq_gate_pkg::word_type flag_two_i,  // source flags, bank two layout
   input  wire irq_gate_pkg::word_type flag_three_i,// source flags, bank three layout
   input  wire irq_gate_pkg::word_type flag_four_i, // source flags, bank four layout
   input  wire logic [3:0]            flag_zero_i,  // flags: timer one, oc one, ic one, ext zero
   output logic [15:0]                rdata_o,      // read data, cycle after strobe
   output logic [15:0]                gate_two_o,   // enable bits bank two
   output logic [15:0]                gate_three_o, // enable bits bank three
   output logic [15:0]                gate_four_o,  // enable bits bank four
   output irq_gate_pkg::level_type    timer_one_level_o,
   output irq_gate_pkg::level_type    out_cmp_one_level_o,
   output irq_gate_pkg::level_type    in_capture_one_level_o,
   output irq_gate_pkg::level_type    ext_line_zero_level_o,
   output logic [15:0]                req_two_o,    // gated requests bank two
   output logic [15:0]                req_three_o,  // gated requests bank three
   output logic [15:0]                req_four_o,   // gated requests bank four
   output logic [3:0]                 req_zero_o    // gated requests of the four level fields
);
   import irq_gate_pkg::*;

   word_type gate_two_q;    // bank two enables
   word_type gate_three_q;  // bank three enables
   word_type gate_four_q;   // bank four enables
   word_type level_zero_q;  // priority fields bank zero
   word_type rdata_q;       // registered read data
   logic     sel_two;       // address decodes
   logic     sel_three;
   logic     sel_four;
   logic     sel_level;

   // decode the index once for writes and reads
   assign sel_two   = (addr_i == `OFS_GATE_TWO);
   assign sel_three = (addr_i == `OFS_GATE_THREE);
   assign sel_four  = (addr_i == `OFS_GATE_FOUR);
   assign sel_level = (addr_i == `OFS_LEVEL_ZERO);

   // bank two bit map, upper byte:
   //   15 timer_six_gate, 14 dma_ch_four_done_gate, 13 unimplemented
   //   12 out_cmp_eight_gate, 11 out_cmp_seven_gate
   //   10 out_cmp_six_gate, 9 out_cmp_five_gate, 8 in_capture_six_gate
   // bank two bit map, lower byte:
   //   7 in_capture_five_gate, 6 in_capture_four_gate
   //   5 in_capture_three_gate, 4 dma_ch_three_done_gate
   //   3 can_one_event_gate, 2 can_one_rx_ready_gate
   //   1 spi_two_event_gate, 0 spi_two_error_gate
   // bank two: timers, dma, compare, capture, can one, spi two
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gate_two_q <= `RST_GATE;
      end else if (wr_i && sel_two) begin
         // bit 13 masked off, the rest map straight across
         gate_two_q <= wdata_i & `MASK_GATE_TWO;
      end
   end

   // bank three bit map, upper byte:
   //   15-14 unimplemented, 13 dma_ch_five_done_gate
   //   12-9 unimplemented, 8 can_two_event_gate
   // bank three bit map, lower byte:
   //   7 can_two_rx_ready_gate, 6 ext_line_four_gate
   //   5 ext_line_three_gate, 4 timer_nine_gate, 3 timer_eight_gate
   //   2 i2c_two_master_gate, 1 i2c_two_slave_gate, 0 timer_seven_gate
   // bank three: dma five, can two, ext lines, timers, i2c two
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gate_three_q <= `RST_GATE;
      end else if (wr_i && sel_three) begin
         gate_three_q <= wdata_i & `MASK_GATE_THREE;
      end
   end

   // bank four bit map: 15-8 unimplemented
   //   7 can_two_tx_request_gate, 6 can_one_tx_request_gate
   //   5 dma_ch_seven_done_gate, 4 dma_ch_six_done_gate
   //   3 unimplemented, 2 uart_two_error_gate
   //   1 uart_one_error_gate, 0 unimplemented
   // bank four: can tx requests, dma six/seven, uart errors
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gate_four_q <= `RST_GATE;
      end else if (wr_i && sel_four) begin
         gate_four_q <= wdata_i & `MASK_GATE_FOUR;
      end
   end

   // level bank zero map: 15 gap, 14-12 timer_one_level
   //   11 gap, 10-8 out_cmp_one_level, 7 gap, 6-4 in_capture_one_level
   //   3 gap, 2-0 ext_line_zero_level
   // codes: 7 highest, 1 lowest, 0 keeps the source silent
   // priority fields; gap bits 15, 11, 7, 3 never store
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         level_zero_q <= `RST_LEVEL_ZERO;
      end else if (wr_i && sel_level) begin
         level_zero_q <= wdata_i & `MASK_LEVEL_ZERO;
      end
   end

   // read port; unmapped indices answer zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_q <= 16'h0000;
      end else if (rd_i) begin
         case (1'b1)
            sel_two:   rdata_q <= gate_two_q;
            sel_three: rdata_q <= gate_three_q;
            sel_four:  rdata_q <= gate_four_q;
            sel_level: rdata_q <= level_zero_q;
            default:   rdata_q <= 16'h0000;
         endcase
      end else begin
         // data stands for one cycle only
         rdata_q <= 16'h0000;
      end
   end

   // register copies toward arbitration, each from its own flop
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gate_two_o             <= `RST_GATE;
         gate_three_o           <= `RST_GATE;
         gate_four_o            <= `RST_GATE;
         timer_one_level_o      <= `RST_LEVEL;
         out_cmp_one_level_o    <= `RST_LEVEL;
         in_capture_one_level_o <= `RST_LEVEL;
         ext_line_zero_level_o  <= `RST_LEVEL;
      end else begin
         // one extra stage keeps outputs flop-driven; copy lags storage by one edge
         gate_two_o             <= gate_two_q;
         gate_three_o           <= gate_three_q;
         gate_four_o            <= gate_four_q;
         timer_one_level_o      <= level_zero_q[`LVL_TIMER_ONE +: 3];
         out_cmp_one_level_o    <= level_zero_q[`LVL_OUT_CMP_ONE +: 3];
         in_capture_one_level_o <= level_zero_q[`LVL_IN_CAP_ONE +: 3];
         ext_line_zero_level_o  <= level_zero_q[`LVL_EXT_ZERO +: 3];
      end
   end

   // request gating: flag and enable; level code zero kills the source
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         req_two_o   <= 16'h0000;
         req_three_o <= 16'h0000;
         req_four_o  <= 16'h0000;
         req_zero_o  <= 4'h0;
      end else begin
         req_two_o   <= flag_two_i & gate_two_q;
         req_three_o <= flag_three_i & gate_three_q;
         req_four_o  <= flag_four_i & gate_four_q;
         // the level bank has no enable of its own here; nonzero level gates it
         req_zero_o  <= {flag_zero_i[3] && (level_zero_q[14:12] != 3'h0),
                         flag_zero_i[2] && (level_zero_q[10:8] != 3'h0),
                         flag_zero_i[1] && (level_zero_q[6:4] != 3'h0),
                         flag_zero_i[0] && (level_zero_q[2:0] != 3'h0)};
      end
   end

   assign rdata_o = rdata_q;

   // assertions; each guards the logic above and names its rule

   // reset clears every enable bank
   reset_gate_a: assert property (@(posedge clk_i) rst_i |=>
      (gate_two_q == 16'h0000 && gate_three_q == 16'h0000 && gate_four_q == 16'h0000))
      else $error("enables not cleared by reset");

   // reset loads code four into every level field
   reset_level_a: assert property (@(posedge clk_i) rst_i |=>
      (level_zero_q == 16'h4444))
      else $error("levels not four after reset");

   // bank two and four enable copies and the timer one and ext zero level copies take reset values at once, not a cycle late
   reset_out_a: assert property (@(posedge clk_i) rst_i |=>
      (gate_two_o == 16'h0000 && gate_four_o == 16'h0000 && timer_one_level_o == 3'h4 && ext_line_zero_level_o == 3'h4))
      else $error("outputs not at reset values");

   // no request leaves during or just after reset
   reset_req_a: assert property (@(posedge clk_i) rst_i |=>
      (req_two_o == 16'h0000 && req_three_o == 16'h0000 && req_four_o == 16'h0000 && req_zero_o == 4'h0))
      else $error("request left during reset");

   // unimplemented enable positions never hold a one
   unimpl_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (gate_two_q[13] == 1'b0 && gate_three_q[15:14] == 2'h0 && gate_three_q[12:9] == 4'h0
       && gate_four_q[15:8] == 8'h00 && gate_four_q[3] == 1'b0 && gate_four_q[0] == 1'b0))
      else $error("unimplemented enable bit set");

   // gap bits of the level bank never hold a one
   level_gap_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (level_zero_q[15] | level_zero_q[11] | level_zero_q[7] | level_zero_q[3]) == 1'b0)
      else $error("level gap bit set");

   // a write to an unmapped index leaves every register alone
   unmapped_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_i && !(sel_two || sel_three || sel_four || sel_level) |=> $stable({gate_two_q, gate_three_q, gate_four_q, level_zero_q}))
      else $error("unmapped write changed a register");

   // bank two stores the written word minus its gap
   write_two_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_i && sel_two |=> gate_two_q == ($past(wdata_i) & 16'hDFFF))
      else $error("bank two write not stored");

   // bank three stores only its ten live bits
   write_three_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_i && sel_three |=> gate_three_q == ($past(wdata_i) & 16'h21FF))
      else $error("bank three write not stored");

   // bank four stores only its six live bits
   write_four_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_i && sel_four |=> gate_four_q == ($past(wdata_i) & 16'h00F6))
      else $error("bank four write not stored");

   // level bank stores the four fields, gaps dropped
   write_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_i && sel_level |=> level_zero_q == ($past(wdata_i) & 16'h7777))
      else $error("level write not stored");

   // without a write nothing moves
   hold_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !wr_i |=> $stable({gate_two_q, gate_three_q, gate_four_q, level_zero_q}))
      else $error("register moved without a write");

   // bank two write then read back to back returns the stored word
   write_back_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_i && sel_two ##1 rd_i && sel_two && !wr_i |=> rdata_o == ($past(wdata_i, 2) & 16'hDFFF))
      else $error("bank two readback wrong");

   // read of bank two answers one cycle later
   read_two_a: assert property (@(posedge clk_i) disable iff (rst_i)
      rd_i && sel_two |=> rdata_o == $past(gate_two_q))
      else $error("bank two read wrong");

   // read of bank three answers one cycle later
   read_three_a: assert property (@(posedge clk_i) disable iff (rst_i)
      rd_i && sel_three |=> rdata_o == $past(gate_three_q))
      else $error("bank three read wrong");

   // read of bank four answers one cycle later
   read_four_a: assert property (@(posedge clk_i) disable iff (rst_i)
      rd_i && sel_four |=> rdata_o == $past(gate_four_q))
      else $error("bank four read wrong");

   // read of the level bank answers one cycle later
   read_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
      rd_i && sel_level |=> rdata_o == $past(level_zero_q))
      else $error("level read wrong");

   // unmapped indices read as zero
   read_unmapped_a: assert property (@(posedge clk_i) disable iff (rst_i)
      rd_i && !(sel_two || sel_three || sel_four || sel_level) |=> rdata_o == 16'h0000)
      else $error("unmapped read not zero");

   // read data stand for one cycle only
   read_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !rd_i |=> rdata_o == 16'h0000)
      else $error("read data stood too long");

   // enable copies trail storage by exactly one edge
   copy_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
      1'b1 |=> (gate_two_o == $past(gate_two_q) && gate_three_o == $past(gate_three_q) && gate_four_o == $past(gate_four_q)))
      else $error("enable copy lags wrongly");

   // timer, compare and capture level copies trail storage by exactly one edge
   copy_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
      1'b1 |=> (timer_one_level_o == $past(level_zero_q[14:12]) && out_cmp_one_level_o == $past(level_zero_q[10:8]) && in_capture_one_level_o == $past(level_zero_q[6:4])))
      else $error("level copy lags wrongly");

   // a level write reaches its output two edges after the strobe
   out_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_i && sel_level ##1 1'b1 |=> ext_line_zero_level_o == $past(level_zero_q[2:0]))
      else $error("level output lags wrongly");

   // a cleared enable blocks its source
   gate_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !gate_three_q[13] |=> !req_three_o[13])
      else $error("disabled source passed");

   // a set enable with a raised flag passes
   gate_pass_a: assert property (@(posedge clk_i) disable iff (rst_i)
      flag_four_i[5] && gate_four_q[5] |=> req_four_o[5])
      else $error("enabled source blocked");

   // every bank request is flag and enable of the cycle before
   req_banks_a: assert property (@(posedge clk_i) disable iff (rst_i)
      1'b1 |=> (req_two_o == $past(flag_two_i & gate_two_q) && req_three_o == $past(flag_three_i & gate_three_q) && req_four_o == $past(flag_four_i & gate_four_q)))
      else $error("bank request wrong");

   // level code zero silences the source
   level_kill_a: assert property (@(posedge clk_i) disable iff (rst_i)
      level_zero_q[14:12] == 3'h0 |=> !req_zero_o[3])
      else $error("level zero source passed");

   // the highest code passes a raised flag
   level_top_a: assert property (@(posedge clk_i) disable iff (rst_i)
      flag_zero_i[3] && level_zero_q[14:12] == 3'h7 |=> req_zero_o[3])
      else $error("highest level source blocked");

   // the lowest nonzero code still passes
   level_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
      flag_zero_i[0] && level_zero_q[2:0] == 3'h1 |=> req_zero_o[0])
      else $error("lowest level source blocked");

   // an intermediate code passes too
   level_mid_a: assert property (@(posedge clk_i) disable iff (rst_i)
      flag_zero_i[2] && level_zero_q[10:8] == 3'h4 |=> req_zero_o[2])
      else $error("middle level source blocked");

   // no flag, no request, whatever the level
   level_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !flag_zero_i[1] |=> !req_zero_o[1])
      else $error("request without a flag");

   // main scenarios: level write, blocked source, passed source, readback, killed level
   cov_write_c: cover property (@(posedge clk_i) wr_i && sel_level ##2 timer_one_level_o == 3'h7);
   cov_block_c: cover property (@(posedge clk_i) flag_two_i[15] && !gate_two_q[15]);
   cov_pass_c: cover property (@(posedge clk_i) req_zero_o[0]);
   cov_reread_c: cover property (@(posedge clk_i) wr_i && sel_four ##1 rd_i && sel_four);
   cov_kill_c: cover property (@(posedge clk_i) flag_zero_i[3] && level_zero_q[14:12] == 3'h0);
endmodule
